// File: inc/rx_sysif_pkg.sv
package rx_sysif_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0]  IDX_CTRL_TIMING = 10'h038;
	localparam logic [9:0]  IDX_BURST_BW    = 10'h03a;
	localparam logic [9:0]  IDX_STATUS      = 10'h03c;
	localparam logic [9:0]  IDX_IRQ_MASK    = 10'h03e;
	localparam logic [9:0]  IDX_MODE        = 10'h034;
	localparam int          ADDR_W          = 12;
	// field positions
	localparam int          GAP_LSB         = 8;
	localparam int          GAP_W           = 3;
	localparam int          XAD_LSB         = 4;
	localparam int          XAD_W           = 3;
	localparam int          PARP_BIT        = 3;
	localparam int          FLVI_BIT        = 2;
	localparam int          REORDER_BIT     = 1;
	localparam int          HEC_BIT         = 0;
	localparam int          MBL_LSB         = 8;
	localparam int          MBL_W           = 6;
	localparam int          LBL_LSB         = 0;
	localparam int          LBL_W           = 8;
	localparam int          CLKACT_BIT      = 0;
	localparam int          BUSMODE_LSB     = 0;
	localparam int          WIDTH_LSB       = 2;
	localparam int          LOOP_BIT        = 4;
	// writable bits and reset values
	localparam logic [15:0] CTRL_MASK       = 16'h077f;
	localparam logic [15:0] BURST_MASK      = 16'h3fff;
	localparam logic [15:0] STAT_MASK       = 16'h0001;
	localparam logic [15:0] MODE_MASK       = 16'h001f;
	localparam logic [15:0] REG_RESET       = 16'h0000;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	typedef enum logic [1:0] {
		MODE_CELL_L2 = 2'h0,
		MODE_CELL_L3 = 2'h1,
		MODE_PKT_L2  = 2'h2,
		MODE_PKT_L3  = 2'h3
	} bus_mode_e;
	typedef enum logic [1:0] {
		WIDTH_8  = 2'h0,
		WIDTH_16 = 2'h1,
		WIDTH_32 = 2'h2
	} width_e;
endpackage

// File: src/clk_activity_detect.sv
module clk_activity_detect (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic sense,
	output logic      edge_seen
);
	logic meta;
	logic stable;
	logic last;

	// two-flop synchroniser, then edge detect on the stable copy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end else begin
			meta   <= sense;
			stable <= meta;
			last   <= stable;
		end
	end

	assign edge_seen = stable & ~last;
endmodule

// File: src/rx_sysif_ctrl.sv
module rx_sysif_ctrl (
	// clock and reset
	input  wire logic                              MCLK,
	input  wire logic                              ARST_N,
	// register bus
	input  wire logic [rx_sysif_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
	input  wire logic                              S_AXI_AWVALID,
	output logic                                   S_AXI_AWREADY,
	input  wire logic [31:0]                       S_AXI_WDATA,
	input  wire logic [3:0]                        S_AXI_WSTRB,
	input  wire logic                              S_AXI_WVALID,
	output logic                                   S_AXI_WREADY,
	output logic [1:0]                             S_AXI_BRESP,
	output logic                                   S_AXI_BVALID,
	input  wire logic                              S_AXI_BREADY,
	input  wire logic [rx_sysif_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
	input  wire logic                              S_AXI_ARVALID,
	output logic                                   S_AXI_ARREADY,
	output logic [31:0]                            S_AXI_RDATA,
	output logic [1:0]                             S_AXI_RRESP,
	output logic                                   S_AXI_RVALID,
	input  wire logic                              S_AXI_RREADY,
	output logic                                   IRQ,
	// receive fifo side
	input  wire logic [31:0]                       SRC_DATA,
	input  wire logic                              SRC_VALID,
	output logic                                   SRC_READY,
	input  wire logic                              SRC_EOP,
	input  wire logic                              SRC_HEC,
	input  wire logic                              SRC_EMPTY,
	input  wire logic                              SRC_AVAIL,
	input  wire logic                              SRC_POLL_AVAIL,
	input  wire logic                              SRC_ABOVE_AE,
	input  wire logic                              SRC_EOP_HELD,
	input  wire logic                              OTHER_PORT_READY,
	// link pins
	input  wire logic                              RX_SYS_CLOCK,
	input  wire logic                              RX_READ_EN_N,
	output logic [31:0]                            RX_DATA,
	output logic                                   RX_PARITY_OUT,
	output logic                                   RX_VALID,
	output logic                                   RX_START_OF_TRANSFER,
	output logic                                   RX_EOP,
	output logic                                   RX_DIRECT_AVAILABLE,
	output logic                                   RX_POLLED_AVAILABLE
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_GAP  = 3'b100
	} state_e;

	// registers
	logic [15:0] ctrl_timing;
	logic [15:0] burst_bw;
	logic [15:0] status;
	logic [15:0] irq_mask;
	logic [15:0] mode_reg;
	// bus slave state
	logic        aw_held;
	logic        w_held;
	logic [9:0]  aw_idx;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	// transfer state
	state_e      state;
	state_e      next_state;
	logic [2:0]  gap_cnt;
	logic [8:0]  burst_cnt;
	logic [7:0]  thr_cnt;
	logic [2:0]  empty_cnt;
	logic        empty_armed;
	logic        drop_hold;
	logic        avail;
	logic        ren_meta;
	logic        ren_sync;
	logic        clk_edge;

	function automatic logic [8:0] burst_limit(input logic [5:0] n, input logic [1:0] w);
		logic [5:0] m;
		m = (w == rx_sysif_pkg::WIDTH_32 && n == 6'h01) ? 6'h02 : n;
		unique case (w)
			rx_sysif_pkg::WIDTH_32: burst_limit = {3'h0, m} + 9'h001;
			rx_sysif_pkg::WIDTH_16: burst_limit = {2'h0, m, 1'b0} + 9'h002;
			default:                burst_limit = {1'b0, m, 2'h0} + 9'h004;
		endcase
	endfunction

	function automatic logic [7:0] bw_divisor(input logic [7:0] x, input logic [1:0] w);
		if (w == rx_sysif_pkg::WIDTH_32 && x < 8'h02) begin
			bw_divisor = 8'h02;
		end else if (x == 8'h00) begin
			bw_divisor = 8'h01;
		end else begin
			bw_divisor = x;
		end
	endfunction

	function automatic logic [31:0] lane_order(input logic [31:0] d, input logic [1:0] w,
		input logic keep);
		unique case (w)
			rx_sysif_pkg::WIDTH_32:
				lane_order = keep ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
			rx_sysif_pkg::WIDTH_16:
				lane_order = keep ? {16'h0000, d[15:0]} : {16'h0000, d[7:0], d[15:8]};
			default:
				lane_order = {24'h000000, d[7:0]};
		endcase
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s, input logic [15:0] m);
		logic [15:0] v;
		v = old;
		if (s[0]) begin
			v[7:0] = d[7:0];
		end
		if (s[1]) begin
			v[15:8] = d[15:8];
		end
		merge16 = v & m;
	endfunction

	// field decode
	wire [2:0]  valid_min_gap        = ctrl_timing[rx_sysif_pkg::GAP_LSB +: rx_sysif_pkg::GAP_W];
	wire [2:0]  cell_avail_drop_time = ctrl_timing[rx_sysif_pkg::XAD_LSB +: rx_sysif_pkg::XAD_W];
	wire        rx_parity_polarity   = ctrl_timing[rx_sysif_pkg::PARP_BIT];
	wire        rx_fill_flag_invert  = ctrl_timing[rx_sysif_pkg::FLVI_BIT];
	wire        rx_byte_reorder_en   = ctrl_timing[rx_sysif_pkg::REORDER_BIT];
	wire        rx_hec_pass          = ctrl_timing[rx_sysif_pkg::HEC_BIT];
	wire [5:0]  rx_max_burst_len     = burst_bw[rx_sysif_pkg::MBL_LSB +: rx_sysif_pkg::MBL_W];
	wire [7:0]  loopback_bw_limit    = burst_bw[rx_sysif_pkg::LBL_LSB +: rx_sysif_pkg::LBL_W];
	wire [1:0]  bus_mode             = mode_reg[rx_sysif_pkg::BUSMODE_LSB +: 2];
	wire [1:0]  bus_width            = mode_reg[rx_sysif_pkg::WIDTH_LSB +: 2];
	wire        loopback_on          = mode_reg[rx_sysif_pkg::LOOP_BIT];
	wire        pkt_l3               = bus_mode == rx_sysif_pkg::MODE_PKT_L3;
	wire        cell_mode            = bus_mode == rx_sysif_pkg::MODE_CELL_L2
	                                 || bus_mode == rx_sysif_pkg::MODE_CELL_L3;
	wire [2:0]  gap_len              = pkt_l3 ? valid_min_gap : 3'h0;
	wire        burst_on             = pkt_l3 && rx_max_burst_len != 6'h00;
	wire [8:0]  burst_max            = burst_limit(rx_max_burst_len, bus_width);

	// bus decode
	wire        aw_take   = S_AXI_AWVALID && !aw_held;
	wire        w_take    = S_AXI_WVALID && !w_held;
	wire        wr_fire   = aw_held && w_held && !S_AXI_BVALID;
	wire        ar_take   = S_AXI_ARVALID && !S_AXI_RVALID;
	wire [9:0]  ar_idx    = S_AXI_ARADDR[rx_sysif_pkg::ADDR_W-1:2];
	wire        rd_status = ar_take && ar_idx == rx_sysif_pkg::IDX_STATUS;
	wire        wr_hit    = aw_idx == rx_sysif_pkg::IDX_CTRL_TIMING
	                     || aw_idx == rx_sysif_pkg::IDX_BURST_BW
	                     || aw_idx == rx_sysif_pkg::IDX_STATUS
	                     || aw_idx == rx_sysif_pkg::IDX_IRQ_MASK
	                     || aw_idx == rx_sysif_pkg::IDX_MODE;
	logic [15:0] rd_word;
	logic        rd_hit;
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 16'h0000;
		unique case (ar_idx)
			rx_sysif_pkg::IDX_CTRL_TIMING: rd_word = ctrl_timing;
			rx_sysif_pkg::IDX_BURST_BW:    rd_word = burst_bw;
			rx_sysif_pkg::IDX_STATUS:      rd_word = status;
			rx_sysif_pkg::IDX_IRQ_MASK:    rd_word = irq_mask;
			rx_sysif_pkg::IDX_MODE:        rd_word = mode_reg;
			default:                       rd_hit = 1'b0;
		endcase
	end

	assign S_AXI_AWREADY = !aw_held;
	assign S_AXI_WREADY  = !w_held;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign IRQ           = |(status & irq_mask);

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_idx       <= 10'h000;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= rx_sysif_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_idx  <= S_AXI_AWADDR[rx_sysif_pkg::ADDR_W-1:2];
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_hit ? rx_sysif_pkg::RESP_OKAY : rx_sysif_pkg::RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= rx_sysif_pkg::RESP_OKAY;
		end else if (ar_take) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= {16'h0000, rd_word};
			S_AXI_RRESP  <= rd_hit ? rx_sysif_pkg::RESP_OKAY : rx_sysif_pkg::RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// register writes
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_timing <= rx_sysif_pkg::REG_RESET;
			burst_bw    <= rx_sysif_pkg::REG_RESET;
			irq_mask    <= rx_sysif_pkg::REG_RESET;
			mode_reg    <= rx_sysif_pkg::REG_RESET;
		end else if (wr_fire) begin
			if (aw_idx == rx_sysif_pkg::IDX_CTRL_TIMING) begin
				ctrl_timing <= merge16(ctrl_timing, w_data, w_strb, rx_sysif_pkg::CTRL_MASK);
			end
			if (aw_idx == rx_sysif_pkg::IDX_BURST_BW) begin
				burst_bw <= merge16(burst_bw, w_data, w_strb, rx_sysif_pkg::BURST_MASK);
			end
			if (aw_idx == rx_sysif_pkg::IDX_IRQ_MASK) begin
				irq_mask <= merge16(irq_mask, w_data, w_strb, rx_sysif_pkg::STAT_MASK);
			end
			if (aw_idx == rx_sysif_pkg::IDX_MODE) begin
				mode_reg <= merge16(mode_reg, w_data, w_strb, rx_sysif_pkg::MODE_MASK);
			end
		end
	end

	// clock activity flag: set wins over clear-on-read
	clk_activity_detect u_clk_act (
		.clk       (MCLK),
		.arst_n    (ARST_N),
		.sense     (RX_SYS_CLOCK),
		.edge_seen (clk_edge)
	);

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			status <= rx_sysif_pkg::REG_RESET;
		end else if (clk_edge) begin
			status[rx_sysif_pkg::CLKACT_BIT] <= 1'b1;
		end else if (rd_status) begin
			status <= rx_sysif_pkg::REG_RESET;
		end
	end

	// read enable from the link passes two flops
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ren_meta <= 1'b0;
			ren_sync <= 1'b0;
		end else begin
			ren_meta <= ~RX_READ_EN_N;
			ren_sync <= ren_meta;
		end
	end

	// transfer control
	wire hec_drop   = cell_mode && SRC_HEC && !rx_hec_pass;
	wire thr_ok     = !loopback_on || thr_cnt == 8'h00;
	wire can_move   = SRC_VALID && ren_sync && thr_ok;
	wire start_ok   = state == ST_IDLE && can_move && gap_cnt == 3'h0;
	wire in_xfer    = state == ST_XFER && can_move;
	wire take       = start_ok || in_xfer;
	wire emit       = take && !hec_drop;
	wire burst_hit  = burst_on && burst_cnt + 9'h001 >= burst_max;
	wire keep_going = !OTHER_PORT_READY && (SRC_ABOVE_AE || SRC_EOP_HELD);
	wire end_burst  = in_xfer && burst_hit && !keep_going;
	wire end_pkt    = in_xfer && SRC_EOP && (OTHER_PORT_READY || gap_len != 3'h0);
	wire leave      = end_burst || end_pkt;

	assign SRC_READY = take;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (start_ok) begin
					next_state = ST_XFER;
				end
			end
			ST_XFER: begin
				if (leave) begin
					next_state = gap_len != 3'h0 ? ST_GAP : ST_IDLE;
				end
			end
			ST_GAP: begin
				if (gap_cnt == 3'h1) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state     <= ST_IDLE;
			gap_cnt   <= 3'h0;
			burst_cnt <= 9'h000;
			thr_cnt   <= 8'h00;
		end else begin
			state <= next_state;
			if (leave) begin
				gap_cnt <= gap_len;
			end else if (gap_cnt != 3'h0) begin
				gap_cnt <= gap_cnt - 3'h1;
			end
			if (start_ok) begin
				burst_cnt <= 9'h001;
			end else if (in_xfer && burst_hit) begin
				burst_cnt <= 9'h000;
			end else if (in_xfer) begin
				burst_cnt <= burst_cnt + 9'h001;
			end
			if (take && loopback_on) begin
				thr_cnt <= bw_divisor(loopback_bw_limit, bus_width) - 8'h01;
			end else if (thr_cnt != 8'h00) begin
				thr_cnt <= thr_cnt - 8'h01;
			end
		end
	end

	// output word
	wire [31:0] out_word = lane_order(SRC_DATA, bus_width, rx_byte_reorder_en);
	wire        out_par  = rx_parity_polarity ? ^out_word : ~^out_word;

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RX_DATA              <= 32'h00000000;
			RX_PARITY_OUT        <= 1'b1;
			RX_VALID             <= 1'b0;
			RX_START_OF_TRANSFER <= 1'b0;
			RX_EOP               <= 1'b0;
		end else begin
			RX_VALID             <= emit;
			RX_START_OF_TRANSFER <= emit && start_ok;
			RX_EOP               <= emit && SRC_EOP;
			if (emit) begin
				RX_DATA       <= out_word;
				RX_PARITY_OUT <= out_par;
			end
		end
	end

	// cell available drop timing
	wire l2_default = bus_mode == rx_sysif_pkg::MODE_CELL_L2 && emit && SRC_EOP;
	wire l3_default = bus_mode == rx_sysif_pkg::MODE_CELL_L3 && emit && start_ok;
	wire counted    = empty_armed && emit && empty_cnt <= 3'h1;
	wire drop_evt   = cell_mode && (cell_avail_drop_time == 3'h0
	                ? (l2_default || l3_default) : counted);

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			empty_armed <= 1'b0;
			empty_cnt   <= 3'h0;
			drop_hold   <= 1'b0;
			avail       <= 1'b0;
		end else begin
			if (SRC_EMPTY && !empty_armed) begin
				empty_armed <= 1'b1;
				empty_cnt   <= cell_avail_drop_time;
			end else if (counted || !SRC_EMPTY) begin
				empty_armed <= 1'b0;
			end else if (empty_armed && emit) begin
				empty_cnt <= empty_cnt - 3'h1;
			end
			if (drop_evt) begin
				drop_hold <= 1'b1;
			end else if (!SRC_AVAIL) begin
				drop_hold <= 1'b0;
			end
			avail <= SRC_AVAIL && !(drop_evt && !l2_default) && !(cell_mode && drop_hold);
		end
	end

	assign RX_DIRECT_AVAILABLE = avail ^ rx_fill_flag_invert;
	assign RX_POLLED_AVAILABLE = SRC_POLL_AVAIL ^ rx_fill_flag_invert;
endmodule

// File: verification/rx_sysif_ctrl_sva.sv
module rx_sysif_ctrl_sva (
	// clock and reset
	input wire logic                            MCLK,
	input wire logic                            ARST_N,
	// register bus
	input wire logic [rx_sysif_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic                            S_AXI_AWVALID,
	input wire logic                            S_AXI_AWREADY,
	input wire logic [31:0]                     S_AXI_WDATA,
	input wire logic                            S_AXI_WVALID,
	input wire logic                            S_AXI_WREADY,
	input wire logic                            S_AXI_BVALID,
	input wire logic                            S_AXI_BREADY,
	input wire logic                            S_AXI_ARREADY,
	input wire logic [31:0]                     S_AXI_RDATA,
	input wire logic                            S_AXI_RVALID,
	input wire logic                            S_AXI_RREADY,
	input wire logic                            IRQ,
	// stream
	input wire logic                            SRC_READY,
	input wire logic                            SRC_HEC,
	input wire logic                            SRC_POLL_AVAIL,
	input wire logic                            RX_READ_EN_N,
	input wire logic [31:0]                     RX_DATA,
	input wire logic                            RX_PARITY_OUT,
	input wire logic                            RX_VALID,
	input wire logic                            RX_START_OF_TRANSFER,
	input wire logic                            RX_POLLED_AVAILABLE
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] wa;
	logic [15:0] ctl;
	logic [1:0]  quiet;
	wire         aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
	wire         w_hs  = S_AXI_WVALID && S_AXI_WREADY;
	wire  [11:0] wadr  = aw_hs ? S_AXI_AWADDR : wa;
	// shadow of the control register, settled three cycles after a write
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wa <= '0;
			ctl <= '0;
			quiet <= '0;
		end else begin
			if (aw_hs) wa <= S_AXI_AWADDR;
			if (w_hs && wadr[11:2] == rx_sysif_pkg::IDX_CTRL_TIMING)
				ctl <= S_AXI_WDATA[15:0] & rx_sysif_pkg::CTRL_MASK;
			if (w_hs) quiet <= '0;
			else if (quiet != 2'h3) quiet <= quiet + 2'h1;
		end
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	property p_parity;
		RX_VALID && quiet == 2'h3 |-> (^{RX_DATA, RX_PARITY_OUT}) == !ctl[rx_sysif_pkg::PARP_BIT];
	endproperty
	a_parity: assert property (p_parity) else $error("parity polarity wrong");
	property p_poll_inv;
		quiet == 2'h3 |-> RX_POLLED_AVAILABLE == (SRC_POLL_AVAIL ^ ctl[rx_sysif_pkg::FLVI_BIT]);
	endproperty
	a_poll_inv: assert property (p_poll_inv) else $error("polled available polarity");
	property p_rdata_upper;
		S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
	property p_sot_valid;
		RX_START_OF_TRANSFER |-> RX_VALID;
	endproperty
	a_sot_valid: assert property (p_sot_valid) else $error("start without valid");
	property p_ren_pause;
		RX_READ_EN_N [*4] |-> !SRC_READY;
	endproperty
	a_ren_pause: assert property (p_ren_pause) else $error("take while read enable off");
	property p_take_emit;
		SRC_READY && !SRC_HEC |=> RX_VALID;
	endproperty
	a_take_emit: assert property (p_take_emit) else $error("taken word not output");
	property p_irq_reset;
		$rose(ARST_N) |-> !IRQ;
	endproperty
	a_irq_reset: assert property (p_irq_reset) else $error("interrupt high after reset");
	property p_bvalid_hold;
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
	property p_rvalid_hold;
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");
	property p_arready;
		S_AXI_ARREADY == !S_AXI_RVALID;
	endproperty
	a_arready: assert property (p_arready) else $error("read address ready wrong");
	c_write: cover property (aw_hs && w_hs);
	c_sot: cover property (RX_START_OF_TRANSFER);
	c_irq: cover property ($rose(IRQ));
endmodule

bind rx_sysif_ctrl rx_sysif_ctrl_sva u_sva (.MCLK(MCLK), .ARST_N(ARST_N),
	.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.IRQ(IRQ), .SRC_READY(SRC_READY), .SRC_HEC(SRC_HEC), .SRC_POLL_AVAIL(SRC_POLL_AVAIL),
	.RX_READ_EN_N(RX_READ_EN_N), .RX_DATA(RX_DATA), .RX_PARITY_OUT(RX_PARITY_OUT),
	.RX_VALID(RX_VALID), .RX_START_OF_TRANSFER(RX_START_OF_TRANSFER),
	.RX_POLLED_AVAILABLE(RX_POLLED_AVAILABLE));

// File: verification/link_layer_model.sv
module link_layer_model (
	// system side
	input  wire logic clk,
	input  wire logic frame,
	input  wire logic pause,
	input  wire logic rx_valid,
	// link pins
	output logic      rx_sys_clock,
	output logic      rx_read_en_n,
	output int        words
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rx_sys_clock = 1'b0;
	initial rx_read_en_n = 1'b1;
	initial words = 0;
	// link clock runs only inside frames and rests low between them
	always #80 rx_sys_clock = frame ? !rx_sys_clock : 1'b0;
	// read enable dropped while the link side wants to pause data
	always @(posedge clk) rx_read_en_n <= pause;
	always @(posedge clk) if (rx_valid === 1'b1) words <= words + 1;
endmodule

// File: verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [11:0] a; logic [31:0] wd, rd; logic [1:0] rr;} row_s;
	typedef struct {logic [31:0] m, c, s, e, k;} srow_s;
	logic        mclk = 0, arst_n = 0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, src_data = '0, rx_data, d;
	logic [1:0]  bresp, rresp, r, br;
	logic        awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic        arvalid = 0, arready, rvalid, rready = 0, irq;
	logic        src_valid = 0, src_ready, src_eop = 0, src_hec = 0, src_avail = 0, src_poll = 0;
	logic        rx_clk, ren_n, par, rx_valid, sot, rx_eop, dir_av, poll_av, frame = 0, pause = 0;
	int          n_fail = 0, check_count = 0, cyc = 0, words, n, w0;
	row_s        rows [6];
	srow_s       srows [6];
	always #10 mclk = ~mclk;
	rx_sysif_ctrl uut (.MCLK(mclk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .IRQ(irq), .SRC_DATA(src_data), .SRC_VALID(src_valid),
		.SRC_READY(src_ready), .SRC_EOP(src_eop), .SRC_HEC(src_hec), .SRC_EMPTY(1'b0),
		.SRC_AVAIL(src_avail), .SRC_POLL_AVAIL(src_poll), .SRC_ABOVE_AE(1'b0),
		.SRC_EOP_HELD(1'b0), .OTHER_PORT_READY(1'b0), .RX_SYS_CLOCK(rx_clk),
		.RX_READ_EN_N(ren_n), .RX_DATA(rx_data), .RX_PARITY_OUT(par), .RX_VALID(rx_valid),
		.RX_START_OF_TRANSFER(sot), .RX_EOP(rx_eop), .RX_DIRECT_AVAILABLE(dir_av),
		.RX_POLLED_AVAILABLE(poll_av));
	link_layer_model partner (.clk(mclk), .frame(frame), .pause(pause), .rx_valid(rx_valid),
		.rx_sys_clock(rx_clk), .rx_read_en_n(ren_n), .words(words));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %b exp %b", $time, m, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		br = bresp;
	endtask
	task automatic axi_rd(input logic [11:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
	task automatic send(input logic [31:0] v, input logic h, output int w);
		w = 0;
		@(posedge mclk);
		src_data <= v;
		src_hec <= h;
		src_eop <= !h;
		src_valid <= 1'b1;
		do begin
			@(posedge mclk);
			w++;
		end while (src_ready !== 1'b1);
		src_valid <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic irq_pass(input logic msk);
		axi_wr(12'h0f8, {31'h0, msk});
		frame <= 1'b1;
		repeat (40) @(posedge mclk);
		chk1(irq, msk, "irq while clock runs");
		frame <= 1'b0;
		repeat (20) @(posedge mclk);
		axi_rd(12'h0f0);
		chk32(d, 32'h1, "clock active latched");
		axi_rd(12'h0f0);
		chk32(d, 32'h0, "status cleared by read");
		chk1(irq, 1'b0, "irq after clear");
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			$display("mismatch at %0t: timeout", $time);
			stop_test();
		end
	end
	initial begin
		rows = '{'{12'h0e0, 32'hffffffff, 32'h077f, 2'h0}, '{12'h0e8, 32'hffffffff, 32'h3fff, 2'h0},
			'{12'h0d0, 32'hffffffff, 32'h001f, 2'h0}, '{12'h0f8, 32'hffffffff, 32'h0001, 2'h0},
			'{12'h0f0, 32'hffffffff, 32'h0000, 2'h0}, '{12'h0fc, 32'hffffffff, 32'h0000, 2'h2}};
		srows = '{'{32'h0a, 32'h00, 32'h44332211, 32'h11223344, 32'hffffffff},
			'{32'h0a, 32'h00, 32'h0, 32'h0, 32'hffffffff},
			'{32'h0a, 32'h0a, 32'h44332211, 32'h44332211, 32'hffffffff},
			'{32'h0a, 32'h08, 32'h0, 32'h0, 32'hffffffff},
			'{32'h06, 32'h08, 32'h2211, 32'h1122, 32'hffff},
			'{32'h02, 32'h02, 32'h11, 32'h11, 32'hff}};
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			axi_wr(rows[i].a, rows[i].wd);
			chk32({30'h0, br}, {30'h0, rows[i].rr}, "write response");
			axi_rd(rows[i].a);
			chk32(d, rows[i].rd, "register readback");
			chk32({30'h0, r}, {30'h0, rows[i].rr}, "read response");
		end
		$display("test registers finished");
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			axi_rd(rows[i].a);
			chk32(d, 32'h0, "value after reset");
		end
		$display("test reset finished");
		foreach (srows[i]) begin
			axi_wr(12'h0d0, srows[i].m);
			axi_wr(12'h0e0, srows[i].c);
			send(srows[i].s, 1'b0, n);
			chk32(rx_data & srows[i].k, srows[i].e, "lane order");
			chk1(^{rx_data & srows[i].k, par}, !srows[i].c[3], "parity");
		end
		$display("test stream finished");
		src_avail <= 1'b1;
		src_poll <= 1'b1;
		for (int i = 1; i >= 0; i--) begin
			axi_wr(12'h0e0, 32'(i * 4));
			repeat (4) @(posedge mclk);
			chk1(poll_av, !i[0], "polled available");
			chk1(dir_av, !i[0], "direct available");
		end
		src_avail <= 1'b0;
		$display("test polarity finished");
		axi_wr(12'h0d0, 32'h08);
		for (int i = 0; i < 2; i++) begin
			axi_wr(12'h0e0, 32'(i));
			w0 = words;
			send(32'h55, 1'b1, n);
			repeat (3) @(posedge mclk);
			chk32(32'(words - w0), 32'(i), "header check byte passed");
		end
		$display("test header finished");
		for (int i = 0; i < 2; i++) begin
			axi_wr(12'h0d0, 32'h0b - i);
			axi_wr(12'h0e0, 32'h300);
			send(32'h2, 1'b0, n);
			send(32'h3, 1'b0, n);
			chk1(n >= 2, !i[0], "valid gap between packets");
		end
		$display("test gap finished");
		axi_wr(12'h0d0, 32'h0a);
		pause <= 1'b1;
		repeat (5) @(posedge mclk);
		fork
			send(32'h1, 1'b0, n);
			begin
				repeat (12) @(posedge mclk);
				pause <= 1'b0;
			end
		join
		chk1(n >= 12, 1'b1, "held while read enable off");
		$display("test pause finished");
		irq_pass(1'b1);
		irq_pass(1'b0);
		$display("test status finished");
		stop_test();
	end
endmodule
